/* rtl/afc_pkg.sv */
// Package: register map, field layout and timing constants for the converter flush and input control block
package afc_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses, word aligned)
  // ----------------------------------------------------------------
  localparam logic [7:0] AFC_OFS_CONTROL = 8'h00;
  localparam logic [7:0] AFC_OFS_STATUS = 8'h04;
  localparam logic [7:0] AFC_OFS_INPUT_SELECT_CONTROL = 8'h10;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AFC_CTRL_FLUSH_BIT = 0;
  localparam int AFC_CTRL_START_BIT = 1;
  localparam int AFC_STAT_BUSY_BIT = 0;
  localparam int AFC_STAT_PEND_BIT = 1;
  localparam int AFC_STAT_FLUSH_BIT = 2;
  localparam int AFC_POS_LSB = 0;
  localparam int AFC_NEG_LSB = 8;
  localparam int AFC_SCAN_LSB = 16;
  localparam int AFC_OFFS_LSB = 20;
  localparam int AFC_GAIN_LSB = 24;
  // Writable bits of the input control register
  localparam logic [31:0] AFC_INPUT_MASK = 32'h0fff1f1f;
  localparam logic [31:0] AFC_INPUT_RESET = 32'h00000000;
  localparam logic [31:0] AFC_UNMAPPED_READ = 32'h00000000;
  // ----------------------------------------------------------------
  // Gain codes
  // ----------------------------------------------------------------
  localparam logic [3:0] AFC_GAIN_MAX_CODE = 4'h4;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int AFC_CLK_MHZ = 200;
  localparam int AFC_CONV_NS = 100;
  localparam int AFC_CONV_CYCLES = (AFC_CONV_NS * AFC_CLK_MHZ + 999) / 1000;
  localparam int AFC_CORE_DIV = 4;

  typedef enum logic [2:0] {
    AFC_IDLE = 3'b001,
    AFC_CONV = 3'b010,
    AFC_FLUSH = 3'b100
  } afc_state_t;
endpackage : afc_pkg

/* rtl/afc_flush_input_ctrl.sv */
// Converter control: pipeline flush sequencing and input selection register behind an Avalon-MM slave
`timescale 1ns/100ps
module afc_flush_input_ctrl
  import afc_pkg::*;
#(
  parameter int CONV_CYCLES = AFC_CONV_CYCLES,
  parameter int CORE_DIV = AFC_CORE_DIV
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_start_trigger,
  output logic o_core_clk_en,
  output logic o_pipe_discard,
  output logic o_result_valid,
  output logic [4:0] o_positive_input_select,
  output logic [4:0] o_negative_input_select,
  output logic [3:0] o_scan_input_count,
  output logic [3:0] o_scan_input_offset,
  output logic [4:0] o_gain_factor
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    afc_state_t st;
    logic ack;
    logic [31:0] rdata;
    logic [31:0] input_ctrl;
    logic pending;
    logic resume;
    logic [7:0] div;
    logic [7:0] conv_cnt;
    logic discard;
    logic result;
    logic [1:0] trig_sync;
    logic trig_prev;
  } afc_regs_t;

  afc_regs_t r_q;
  afc_regs_t r_d;
  logic access;
  logic wr_ctrl;
  logic flush_req;
  logic start_req;
  logic core_tick;
  logic trig_rise;

  // Gain code to multiplier; undefined codes fall back to unity
  function automatic logic [4:0] afc_gain_decode(input logic [3:0] code);
    if (code <= AFC_GAIN_MAX_CODE) begin
      afc_gain_decode = 5'h01 << code[2:0];
    end else begin
      afc_gain_decode = 5'h01;
    end
  endfunction : afc_gain_decode

  function automatic logic [31:0] afc_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    afc_merge = m;
  endfunction : afc_merge

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One wait cycle per access: request held, answered at the ack edge
  assign access = (i_avs_read | i_avs_write) & ~r_q.ack;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~r_q.ack;
  assign wr_ctrl = access & i_avs_write & (i_avs_address == AFC_OFS_CONTROL) & i_avs_byteenable[0];
  assign flush_req = wr_ctrl & i_avs_writedata[AFC_CTRL_FLUSH_BIT];
  assign start_req = wr_ctrl & i_avs_writedata[AFC_CTRL_START_BIT];
  assign core_tick = (r_q.div == 8'(CORE_DIV - 1));
  // Trigger pin is asynchronous; only the second stage is examined
  assign trig_rise = r_q.trig_sync[1] & ~r_q.trig_prev;

  always_comb begin
    r_d = r_q;
    r_d.ack = access;
    r_d.discard = 1'b0;
    r_d.result = 1'b0;
    r_d.trig_sync = {r_q.trig_sync[0], i_start_trigger};
    r_d.trig_prev = r_q.trig_sync[1];
    r_d.div = core_tick ? 8'h00 : r_q.div + 8'h01;
    if (access & i_avs_read) begin
      if (i_avs_address == AFC_OFS_CONTROL) begin
        r_d.rdata = 32'h00000000;
        r_d.rdata[AFC_CTRL_FLUSH_BIT] = (r_q.st == AFC_FLUSH);
      end else if (i_avs_address == AFC_OFS_STATUS) begin
        r_d.rdata = 32'h00000000;
        r_d.rdata[AFC_STAT_BUSY_BIT] = (r_q.st == AFC_CONV);
        r_d.rdata[AFC_STAT_PEND_BIT] = r_q.pending;
        r_d.rdata[AFC_STAT_FLUSH_BIT] = (r_q.st == AFC_FLUSH);
      end else if (i_avs_address == AFC_OFS_INPUT_SELECT_CONTROL) begin
        r_d.rdata = r_q.input_ctrl;
      end else begin
        r_d.rdata = AFC_UNMAPPED_READ;
      end
    end
    if (access & i_avs_write & (i_avs_address == AFC_OFS_INPUT_SELECT_CONTROL)) begin
      r_d.input_ctrl = afc_merge(r_q.input_ctrl, i_avs_writedata, i_avs_byteenable) & AFC_INPUT_MASK;
    end
    if (start_req | trig_rise) begin
      r_d.pending = 1'b1;
    end
    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    case (r_q.st)
      AFC_IDLE: begin
        if (r_q.pending & core_tick) begin
          r_d.st = AFC_CONV;
          r_d.pending = start_req | trig_rise;
          r_d.conv_cnt = 8'h00;
        end
      end
      AFC_CONV: begin
        if (core_tick) begin
          if (r_q.conv_cnt == 8'(CONV_CYCLES - 1)) begin
            r_d.st = AFC_IDLE;
            r_d.result = 1'b1;
          end else begin
            r_d.conv_cnt = r_q.conv_cnt + 8'h01;
          end
        end
      end
      AFC_FLUSH: begin
        // Flush lasts one cycle, then the bit reads back as zero
        r_d.st = AFC_IDLE;
        r_d.pending = r_q.pending | r_q.resume | start_req | trig_rise;
        r_d.resume = 1'b0;
      end
      default: begin
        r_d.st = AFC_IDLE;
      end
    endcase
    // Flush overrides everything, including a completing conversion
    if (flush_req) begin
      r_d.st = AFC_FLUSH;
      r_d.discard = 1'b1;
      r_d.result = 1'b0;
      r_d.resume = (r_q.st == AFC_CONV) | r_q.resume;
      // Keep a queued start even if the sequencer consumed it in this cycle
      r_d.pending = r_q.pending | start_req | trig_rise;
      r_d.div = 8'h00;
      r_d.conv_cnt = 8'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_q <= '{st: AFC_IDLE, input_ctrl: AFC_INPUT_RESET, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_avs_readdata = r_q.rdata;
  assign o_core_clk_en = core_tick & (r_q.st != AFC_FLUSH);
  assign o_pipe_discard = r_q.discard;
  assign o_result_valid = r_q.result;
  assign o_positive_input_select = r_q.input_ctrl[AFC_POS_LSB +: 5];
  assign o_negative_input_select = r_q.input_ctrl[AFC_NEG_LSB +: 5];
  assign o_scan_input_count = r_q.input_ctrl[AFC_SCAN_LSB +: 4];
  assign o_scan_input_offset = r_q.input_ctrl[AFC_OFFS_LSB +: 4];
  assign o_gain_factor = afc_gain_decode(r_q.input_ctrl[AFC_GAIN_LSB +: 4]);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_flush_discards: assert property (@(posedge i_clk) disable iff (!i_rstn)
    flush_req |=> o_pipe_discard && r_q.st == AFC_FLUSH) else $error("flush did not discard");
  a_flush_clk_restart: assert property (@(posedge i_clk) disable iff (!i_rstn)
    flush_req |=> r_q.div == 8'h00) else $error("divider not restarted");
  a_flush_no_result: assert property (@(posedge i_clk) disable iff (!i_rstn)
    flush_req |=> !o_result_valid ##1 !o_result_valid) else $error("result delivered across flush");
  a_flush_selfclear: assert property (@(posedge i_clk) disable iff (!i_rstn)
    r_q.st == AFC_FLUSH && !flush_req |=> r_q.st == AFC_IDLE) else $error("flush bit stuck");
  a_flush_resume: assert property (@(posedge i_clk) disable iff (!i_rstn)
    flush_req && r_q.st == AFC_CONV |=> ##1 r_q.pending || r_q.st == AFC_FLUSH) else $error("conversion not resumed");
  a_zero_no_flush: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_ctrl && !i_avs_writedata[AFC_CTRL_FLUSH_BIT] && r_q.st != AFC_FLUSH |=> r_q.st != AFC_FLUSH)
    else $error("zero write flushed");
  a_gain_decode: assert property (@(posedge i_clk) disable iff (!i_rstn)
    r_q.input_ctrl[27:24] == 4'h3 |-> o_gain_factor == 5'h08) else $error("gain decode wrong");
  a_gain_max: assert property (@(posedge i_clk) disable iff (!i_rstn)
    r_q.input_ctrl[27:24] == 4'h4 |-> o_gain_factor == 5'h10) else $error("gain 16 wrong");
  a_input_store: assert property (@(posedge i_clk) disable iff (!i_rstn)
    access && i_avs_write && i_avs_address == AFC_OFS_INPUT_SELECT_CONTROL && i_avs_byteenable == 4'hf
    |=> o_positive_input_select == $past(i_avs_writedata[4:0])) else $error("input select not stored");
  a_flush_keeps_pending: assert property (@(posedge i_clk) disable iff (!i_rstn)
    flush_req && r_q.pending |=> r_q.pending) else $error("pending start lost at flush");
  a_discard_no_result: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_pipe_discard |-> !o_result_valid) else $error("result beside discard");
  c_flush_during_conv: cover property (@(posedge i_clk) disable iff (!i_rstn) flush_req && r_q.st == AFC_CONV);
  c_result: cover property (@(posedge i_clk) disable iff (!i_rstn) o_result_valid);
  c_flush_idle: cover property (@(posedge i_clk) disable iff (!i_rstn) flush_req && r_q.st == AFC_IDLE);
  c_flush_pending: cover property (@(posedge i_clk) disable iff (!i_rstn) flush_req && r_q.pending);
endmodule : afc_flush_input_ctrl

/* bench/afc_core_model.sv */
// Converter core model: counts results and flushes, drives the start pin
`timescale 1ns/100ps
module afc_core_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_core_clk_en,
  input wire logic i_pipe_discard,
  input wire logic i_result_valid,
  input wire logic i_go,
  output logic o_start_trigger,
  output int o_n_res,
  output int o_n_disc,
  output int o_gap
);
  int since;
  // Gap counts cycles from the discard pulse to the first converter clock after it
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_start_trigger <= 1'b0;
      o_n_res <= 0;
      o_n_disc <= 0;
      o_gap <= 0;
      since <= -1;
    end else begin
      o_start_trigger <= i_go;
      if (i_result_valid) o_n_res <= o_n_res + 1;
      if (i_pipe_discard) begin
        o_n_disc <= o_n_disc + 1;
        since <= 0;
      end else if (since >= 0 && i_core_clk_en) begin
        o_gap <= since + 1;
        since <= -1;
      end else if (since >= 0) since <= since + 1;
    end
  end
endmodule : afc_core_model

/* bench/testbench.sv */
// Self-checking bench for the flush and input control block
`timescale 1ns/100ps
module testbench;
  import afc_pkg::*;
  localparam int DIV = 2;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [7:0] i_avs_address = 8'h00;
  logic [31:0] i_avs_writedata = 32'h00000000;
  logic [3:0] i_avs_byteenable = 4'hf;
  logic go = 1'b0;
  logic trig, o_avs_waitrequest, o_core_clk_en, o_pipe_discard, o_result_valid;
  logic [31:0] o_avs_readdata, q, e;
  logic [4:0] o_positive_input_select, o_negative_input_select, o_gain_factor;
  logic [3:0] o_scan_input_count, o_scan_input_offset;
  int n_res, n_disc, gap, r0, num_errors = 0, cmp_count = 0, cyc = 0;
  logic [31:0] row_wr [7] = '{32'h00000000, 32'h01000015, 32'h12345678, 32'h03000a1f, 32'h04ffffff,
    32'hffffffff, 32'h05000000};
  logic [4:0] row_gain [7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h01, 5'h01};

  afc_flush_input_ctrl #(.CONV_CYCLES(2), .CORE_DIV(DIV)) uut (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_start_trigger(trig), .o_core_clk_en(o_core_clk_en),
    .o_pipe_discard(o_pipe_discard), .o_result_valid(o_result_valid),
    .o_positive_input_select(o_positive_input_select), .o_negative_input_select(o_negative_input_select),
    .o_scan_input_count(o_scan_input_count), .o_scan_input_offset(o_scan_input_offset),
    .o_gain_factor(o_gain_factor));
  afc_core_model core (.i_clk(i_clk), .i_rstn(i_rstn), .i_core_clk_en(o_core_clk_en),
    .i_pipe_discard(o_pipe_discard), .i_result_valid(o_result_valid), .i_go(go), .o_start_trigger(trig),
    .o_n_res(n_res), .o_n_disc(n_disc), .o_gap(gap));

  always #2.5 i_clk = ~i_clk;

  // ----------------------------------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------------------------------
  // Waitrequest and read data are taken at the rising edge, before the registers move
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    do begin
      @(posedge i_clk);
    end while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(posedge i_clk);
  endtask : bus

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    chk("gain at reset", 32'(o_gain_factor), 32'h1);
    bus(1'b0, AFC_OFS_INPUT_SELECT_CONTROL, 32'h0, q);
    chk("input ctl reset", q, AFC_INPUT_RESET);
    bus(1'b0, 8'h08, 32'h0, q);
    chk("unmapped read", q, AFC_UNMAPPED_READ);
    for (int i = 0; i < 7; i++) begin
      e = row_wr[i] & AFC_INPUT_MASK;
      bus(1'b1, AFC_OFS_INPUT_SELECT_CONTROL, row_wr[i], q);
      bus(1'b0, AFC_OFS_INPUT_SELECT_CONTROL, 32'h0, q);
      chk("input ctl", q, e);
      chk("pos and neg", {o_negative_input_select, o_positive_input_select}, {e[12:8], e[4:0]});
      chk("scan", {o_scan_input_offset, o_scan_input_count}, e[23:16]);
      chk("gain", 32'(o_gain_factor), 32'(row_gain[i]));
    end
    // Only the low byte lane may change
    i_avs_byteenable <= 4'h1;
    bus(1'b1, AFC_OFS_INPUT_SELECT_CONTROL, 32'hffffffff, q);
    i_avs_byteenable <= 4'hf;
    bus(1'b0, AFC_OFS_INPUT_SELECT_CONTROL, 32'h0, q);
    chk("byte lanes", q, 32'h0500001f);
    bus(1'b1, AFC_OFS_CONTROL, 32'h0, q);
    chk("zero write", n_disc, 0);
    go <= 1'b1;
    repeat (4) @(posedge i_clk);
    go <= 1'b0;
    repeat (40) @(posedge i_clk);
    chk("pin conversion", n_res, 1);
    r0 = n_res;
    bus(1'b1, AFC_OFS_CONTROL, 32'h2, q);
    bus(1'b1, AFC_OFS_CONTROL, 32'h1, q);
    chk("aborted result", n_res, r0);
    chk("discard pulses", n_disc, 1);
    bus(1'b0, AFC_OFS_CONTROL, 32'h0, q);
    chk("flush bit", 32'(q[AFC_CTRL_FLUSH_BIT]), 32'h0);
    chk("restart gap", gap, DIV - 1);
    repeat (40) @(posedge i_clk);
    chk("resumed result", n_res, r0 + 1);
    bus(1'b0, AFC_OFS_STATUS, 32'h0, q);
    chk("status idle", q, 32'h0);
    end_sim();
  end
endmodule : testbench
